// ---- wshj_top.v ----
// section hold and judge over a load/position sample stream, five sections
// assumes samples in position order; under back reference the stored
// waveform is replayed after measurement with positions counted from its end
//
// How it works
// - drop beyond difference marks max and min
// - rebound beyond rate times drop confirms pair
// - hold the pair matching the ordinal
// - two inflection intervals, 1 to 999 units
// - change difference over threshold marks inflection
// - keep largest inflection change in section
// - inflection starts at start-load crossing, else start
// - section points 0..2047 front, -2047..0 back
// - reject start/end order wrong for reference
// - shared point: later front, earlier back
// - skipped start: first sample inside holds
// - load OK within HI/LO; bad limits rejected
// - position limits on displacement axis; end range wider
// - section is hold input or programmed span
// - always mode judges every sample, holds nothing
// - sample mode holds load at section start
// - peak, bottom and peak-to-peak holds
// - relative detection starts at start-load crossing
// - average of section, at completion on displacement
// - end position judged from origin, last section only
// - crossing in either direction counts
// - one to five sections
// - detection ordinal 1 to 15
// - relative difference 1 to 19998
`timescale 1ns/1ps
`include "wshj_defs.vh"
module wshj_top #(
	parameter W = 16
) (
	input  wire                   sys_clk,
	input  wire                   rst,
	input  wire                   measStart,
	input  wire                   measEnd,
	input  wire                   sampleValid,
	input  wire signed [W-1:0]    sampleLoad,
	input  wire signed [W-1:0]    position_value,
	input  wire signed [W-1:0]    endPosition,
	input  wire                   holdIn,
	input  wire                   extSwitch,
	input  wire                   backRef,
	input  wire                   dispAxis,
	input  wire        [2:0]      numSect,
	input  wire        [19:0]     cfgMode,
	input  wire        [5*W-1:0]  cfgStart,
	input  wire        [5*W-1:0]  cfgEnd,
	input  wire        [5*W-1:0]  loadHi,
	input  wire        [5*W-1:0]  loadLo,
	input  wire        [5*W-1:0]  posHi,
	input  wire        [5*W-1:0]  posLo,
	input  wire        [5*W-1:0]  startLoad,
	input  wire        [4:0]      startLoadEn,
	input  wire        [5*W-1:0]  relDiff,
	input  wire        [19:0]     relRate,
	input  wire        [19:0]     relOrdinal,
	input  wire        [49:0]     intA,
	input  wire        [49:0]     intB,
	input  wire        [5*W-1:0]  inflDiff,
	output reg         [5*W-1:0]  heldLoad,
	output reg         [5*W-1:0]  heldPos,
	output reg         [4:0]      sectDone,
	output reg         [4:0]      sectPass,
	output reg         [4:0]      sectFail,
	output reg         [4:0]      cfgError,
	output reg                    busy
);
	function signed [W-1:0] pick(input [5*W-1:0] v, input [2:0] k);
		pick = v[k*W +: W];
	endfunction
	function [3:0] pick4(input [19:0] v, input [2:0] k);
		pick4 = v[k*4 +: 4];
	endfunction
	function inLim(input signed [W-1:0] v, input signed [W-1:0] lo,
		input signed [W-1:0] hi);
		inLim = (v >= lo) && (v <= hi);
	endfunction

	reg        [2:0]   cur;
	reg        [2:0]   extIdx;
	reg signed [W-1:0] maxL;
	reg signed [W-1:0] maxP;
	reg signed [W-1:0] minL;
	reg signed [W-1:0] minP;
	reg signed [W-1:0] firstL;
	reg signed [W-1:0] firstP;
	reg signed [35:0]  sum;
	reg        [19:0]  cnt;
	reg                seen;
	reg                bad;
	reg                armed;
	reg                above;
	reg        [2:0]   hit;
	reg        [4:0]   next_cfgError;
	integer            i;
	integer            j;
	reg signed [W-1:0] s;
	reg signed [W-1:0] e;
	reg signed [W-1:0] mStart;
	reg signed [W-1:0] mEnd;
	reg signed [W-1:0] fVal;
	reg signed [W-1:0] fPos;
	reg                fHave;
	reg                fUsePos;

	// section membership; loop order settles the shared point
	always @* begin
		hit = `WSHJ_NONE;
		mStart = {W{1'b0}};
		mEnd = {W{1'b0}};
		for (j = 0; j < 5; j = j + 1) begin
			mStart = pick(cfgStart, j[2:0]);
			mEnd = pick(cfgEnd, j[2:0]);
			if (j < numSect && pick4(cfgMode, j[2:0]) != `WSHJ_M_ENDDISP) begin
				if (!backRef && position_value >= mStart && position_value <= mEnd)
					hit = j[2:0];
				else if (backRef && position_value <= mStart && position_value >= mEnd
					&& hit == `WSHJ_NONE)
					hit = j[2:0];
			end
		end
	end

	// external switching is not possible under back reference
	wire [2:0] nextSect = (backRef || !extSwitch) ? hit :
		((holdIn && extIdx < numSect) ? extIdx : `WSHJ_NONE);
	wire [2:0] curIdx = (cur == `WSHJ_NONE) ? 3'h0 : cur;
	wire [2:0] selIdx = (nextSect != `WSHJ_NONE) ? nextSect : curIdx;
	wire [3:0] sMode = pick4(cfgMode, selIdx);
	wire [3:0] fMode = pick4(cfgMode, curIdx);
	wire signed [W-1:0] sStartLd = pick(startLoad, selIdx);
	wire entry = sampleValid && nextSect != `WSHJ_NONE && nextSect != cur;
	wire leave = (sampleValid && cur != `WSHJ_NONE && nextSect != cur)
		|| (measEnd && cur != `WSHJ_NONE);
	wire inSample = sampleValid && nextSect != `WSHJ_NONE;
	wire detStrobe = inSample && !entry;
	wire nowAbove = sampleLoad >= sStartLd;
	wire crossNow = seen && !entry && (nowAbove != above);
	wire armedNow = armed || !startLoadEn[selIdx] || crossNow;
	wire [2:0] lastIdx = numSect - 3'h1;

	wire exFound;
	wire signed [W-1:0] exMaxL;
	wire signed [W-1:0] exMaxP;
	wire signed [W-1:0] exMinL;
	wire signed [W-1:0] exMinP;
	wire inFound;
	wire signed [W-1:0] inLoad;
	wire signed [W-1:0] inPos;

	wshj_extrema #(.W(W)) i_wshj_extrema (
		.sys_clk (sys_clk),
		.rst     (rst),
		.restart (entry),
		.strobe  (detStrobe),
		.armed   (armedNow),
		.load    (sampleLoad),
		.pos     (position_value),
		.diff    (pick(relDiff, selIdx)),
		.rate    (pick4(relRate, selIdx)),
		.ordinal (pick4(relOrdinal, selIdx)),
		.found   (exFound),
		.maxLoad (exMaxL),
		.maxPos  (exMaxP),
		.minLoad (exMinL),
		.minPos  (exMinP)
	);

	wshj_inflect #(.W(W)) i_wshj_inflect (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.restart  (entry),
		.strobe   (detStrobe),
		.armed    (armedNow),
		.load     (sampleLoad),
		.pos      (position_value),
		.intA     (intA[selIdx*10 +: 10]),
		.intB     (intB[selIdx*10 +: 10]),
		.thresh   (pick(inflDiff, selIdx)),
		.found    (inFound),
		.bestLoad (inLoad),
		.bestPos  (inPos)
	);

	// divider only sees the closing section; cost traded for simplicity
	// both arms signed, so a negative sum divides as signed
	wire signed [35:0] avg = (cnt == 20'h0) ? $signed(36'h0)
		: sum / $signed({16'h0000, cnt});

	// held value of the section being closed
	always @* begin
		fVal = {W{1'b0}};
		fPos = {W{1'b0}};
		fHave = seen;
		fUsePos = 1'b1;
		case (fMode)
			`WSHJ_M_SAMPLE: begin
				fVal = firstL;
				fPos = firstP;
			end
			`WSHJ_M_PEAK: begin
				fVal = maxL;
				fPos = maxP;
			end
			`WSHJ_M_BOTTOM: begin
				fVal = minL;
				fPos = minP;
			end
			`WSHJ_M_P2P: begin
				fVal = maxL - minL;
				fUsePos = 1'b0;
			end
			`WSHJ_M_RELMAX: begin
				fVal = exMaxL;
				fPos = exMaxP;
				fHave = exFound;
			end
			`WSHJ_M_RELMIN: begin
				fVal = exMinL;
				fPos = exMinP;
				fHave = exFound;
			end
			`WSHJ_M_INFLECT: begin
				fVal = inLoad;
				fPos = inPos;
				fHave = inFound;
			end
			`WSHJ_M_AVERAGE: begin
				fVal = avg[W-1:0];
				fUsePos = 1'b0;
			end
			default: fUsePos = 1'b0;
		endcase
	end

	wire loadOk = inLim(fVal, pick(loadLo, curIdx), pick(loadHi, curIdx));
	wire posOk = !fUsePos || !dispAxis
		|| inLim(fPos, pick(posLo, curIdx), pick(posHi, curIdx));
	wire fPass = (fMode == `WSHJ_M_ALWAYS) ? (seen && !bad)
		: (fHave && loadOk && posOk);
	// results that must wait for measurement completion
	wire defer = (fMode == `WSHJ_M_AVERAGE && dispAxis)
		|| (fMode == `WSHJ_M_SAMPLE && backRef);
	wire lastEnd = pick4(cfgMode, lastIdx) == `WSHJ_M_ENDDISP && dispAxis;
	wire endOk = inLim(endPosition, pick(posLo, lastIdx), pick(posHi, lastIdx));

	// setting checks, refreshed every cycle
	always @* begin
		next_cfgError = 5'h00;
		s = {W{1'b0}};
		e = {W{1'b0}};
		for (i = 0; i < 5; i = i + 1) begin
			if (i < numSect) begin
				s = pick(cfgStart, i[2:0]);
				e = pick(cfgEnd, i[2:0]);
				if (backRef ? (s < e || s > 0 || e < $signed(`WSHJ_POS_MIN))
					: (s > e || s < 0 || e > $signed(`WSHJ_POS_MAX)))
					next_cfgError[i] = 1'b1;
				if (pick(loadHi, i[2:0]) < pick(loadLo, i[2:0])
					|| pick(loadHi, i[2:0]) > $signed(`WSHJ_LOAD_MAX)
					|| pick(loadLo, i[2:0]) < $signed(`WSHJ_LOAD_MIN))
					next_cfgError[i] = 1'b1;
				if (dispAxis && (pick(posHi, i[2:0]) < pick(posLo, i[2:0])
					|| (pick4(cfgMode, i[2:0]) == `WSHJ_M_ENDDISP
					? (pick(posHi, i[2:0]) > $signed(`WSHJ_END_MAX)
					|| pick(posLo, i[2:0]) < $signed(`WSHJ_LOAD_MIN))
					: (pick(posHi, i[2:0]) > $signed(`WSHJ_POS_MAX)
					|| pick(posLo, i[2:0]) < $signed(`WSHJ_POS_MIN)))))
					next_cfgError[i] = 1'b1;
				if ((pick4(cfgMode, i[2:0]) == `WSHJ_M_RELMAX
					|| pick4(cfgMode, i[2:0]) == `WSHJ_M_RELMIN)
					&& (pick(relDiff, i[2:0]) < $signed(16'h0001)
					|| pick(relDiff, i[2:0]) > $signed(`WSHJ_DIFF_MAX)
					|| pick4(relOrdinal, i[2:0]) == 4'h0
					|| pick4(relRate, i[2:0]) > `WSHJ_RATE_MAX))
					next_cfgError[i] = 1'b1;
				if (pick4(cfgMode, i[2:0]) == `WSHJ_M_INFLECT
					&& (intA[i*10 +: 10] == 10'h000 || intA[i*10 +: 10] > `WSHJ_INT_MAX
					|| intB[i*10 +: 10] == 10'h000 || intB[i*10 +: 10] > `WSHJ_INT_MAX))
					next_cfgError[i] = 1'b1;
				if (pick4(cfgMode, i[2:0]) == `WSHJ_M_ENDDISP
					&& (i[2:0] != lastIdx || !dispAxis))
					next_cfgError[i] = 1'b1;
				if (pick4(cfgMode, i[2:0]) > `WSHJ_M_ENDDISP)
					next_cfgError[i] = 1'b1;
			end
		end
		if (numSect == 3'h0 || numSect > `WSHJ_SECT_MAX)
			next_cfgError = 5'h1F;
	end

	// section tracking, accumulation and result capture
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cur <= `WSHJ_NONE;
			extIdx <= 3'h0;
			maxL <= {W{1'b0}};
			maxP <= {W{1'b0}};
			minL <= {W{1'b0}};
			minP <= {W{1'b0}};
			firstL <= {W{1'b0}};
			firstP <= {W{1'b0}};
			sum <= 36'h0;
			cnt <= 20'h0;
			seen <= 1'b0;
			bad <= 1'b0;
			armed <= 1'b0;
			above <= 1'b0;
			heldLoad <= {(5*W){1'b0}};
			heldPos <= {(5*W){1'b0}};
			sectDone <= 5'h00;
			sectPass <= 5'h00;
			sectFail <= 5'h00;
			cfgError <= 5'h00;
			busy <= 1'b0;
		end else begin
			cfgError <= next_cfgError;
			if (measStart) begin
				// a new measurement wipes all results
				cur <= `WSHJ_NONE;
				extIdx <= 3'h0;
				heldLoad <= {(5*W){1'b0}};
				heldPos <= {(5*W){1'b0}};
				sectDone <= 5'h00;
				sectPass <= 5'h00;
				sectFail <= 5'h00;
				busy <= 1'b1;
			end else begin
				if (leave) begin
					if (fMode != `WSHJ_M_ALWAYS) begin
						heldLoad[curIdx*W +: W] <= fVal;
						heldPos[curIdx*W +: W] <= fPos;
					end
					sectPass[curIdx] <= fPass;
					sectFail[curIdx] <= !fPass;
					if (!defer || measEnd)
						sectDone[curIdx] <= 1'b1;
					if (extSwitch && !backRef)
						extIdx <= extIdx + 3'h1;
					cur <= measEnd ? `WSHJ_NONE : nextSect;
				end else if (entry) begin
					cur <= nextSect;
				end
				if (measEnd) begin
					busy <= 1'b0;
					// the section closed by this pulse is final as well
					sectDone <= sectDone | sectPass | sectFail
						| (leave ? (5'h01 << curIdx) : 5'h00);
					if (lastEnd) begin
						heldPos[lastIdx*W +: W] <= endPosition;
						sectPass[lastIdx] <= endOk;
						sectFail[lastIdx] <= !endOk;
						sectDone[lastIdx] <= 1'b1;
					end
				end
			end
			// accumulators restart on the first sample of a section
			if (inSample && !measStart) begin
				seen <= 1'b1;
				above <= nowAbove;
				armed <= armedNow && !entry ? 1'b1 : !startLoadEn[selIdx];
				if (entry || sampleLoad > maxL) begin
					maxL <= sampleLoad;
					maxP <= position_value;
				end
				if (entry || sampleLoad < minL) begin
					minL <= sampleLoad;
					minP <= position_value;
				end
				if (entry) begin
					firstL <= sampleLoad;
					firstP <= position_value;
				end
				sum <= (entry ? 36'h0 : sum) + {{20{sampleLoad[W-1]}}, sampleLoad};
				cnt <= (entry ? 20'h0 : cnt) + 20'h1;
				if (sMode == `WSHJ_M_ALWAYS && !inLim(sampleLoad, pick(loadLo, selIdx),
					pick(loadHi, selIdx)))
					bad <= 1'b1;
				else if (entry)
					bad <= 1'b0;
			end else if (leave) begin
				seen <= 1'b0;
			end
		end
	end
endmodule

// ---- wshj_defs.vh ----
// constants of the waveform section hold and judge block
// assumes loads and positions arrive as 16-bit two's complement counts
`ifndef WSHJ_DEFS_VH
`define WSHJ_DEFS_VH
// hold methods
`define WSHJ_M_ALWAYS   4'h0
`define WSHJ_M_SAMPLE   4'h1
`define WSHJ_M_PEAK     4'h2
`define WSHJ_M_BOTTOM   4'h3
`define WSHJ_M_P2P      4'h4
`define WSHJ_M_RELMAX   4'h5
`define WSHJ_M_RELMIN   4'h6
`define WSHJ_M_INFLECT  4'h7
`define WSHJ_M_AVERAGE  4'h8
`define WSHJ_M_ENDDISP  4'h9
// section index meaning no section
`define WSHJ_NONE       3'h7
`define WSHJ_SECT_MAX   3'h5
// limit ranges
`define WSHJ_LOAD_MAX   16'h270F
`define WSHJ_LOAD_MIN   16'hD8F1
`define WSHJ_POS_MAX    16'h07FF
`define WSHJ_POS_MIN    16'hF801
`define WSHJ_END_MAX    16'h7D00
`define WSHJ_DIFF_MAX   16'h4E1E
`define WSHJ_INT_MAX    10'h3E7
`define WSHJ_RATE_MAX   4'h9
`define WSHJ_MARGIN     16'h000A
`endif

// ---- wshj_extrema.v ----
// relative maximum / minimum detector for one active section
// assumes samples arrive in order and restart pulses at section entry
`timescale 1ns/1ps
`include "wshj_defs.vh"
module wshj_extrema #(
	parameter W = 16
) (
	input  wire                sys_clk,
	input  wire                rst,
	input  wire                restart,
	input  wire                strobe,
	input  wire                armed,
	input  wire signed [W-1:0] load,
	input  wire signed [W-1:0] pos,
	input  wire        [W-1:0] diff,
	input  wire        [3:0]   rate,
	input  wire        [3:0]   ordinal,
	output reg                 found,
	output reg  signed [W-1:0] maxLoad,
	output reg  signed [W-1:0] maxPos,
	output reg  signed [W-1:0] minLoad,
	output reg  signed [W-1:0] minPos
);
	// rate setting in quarters of the drop
	function [4:0] quarters(input [3:0] r);
		case (r)
			4'h0: quarters = 5'h01;
			4'h1: quarters = 5'h02;
			4'h2: quarters = 5'h03;
			4'h3: quarters = 5'h04;
			4'h4: quarters = 5'h05;
			4'h5: quarters = 5'h06;
			4'h6: quarters = 5'h07;
			4'h7: quarters = 5'h08;
			4'h8: quarters = 5'h0C;
			default: quarters = 5'h10;
		endcase
	endfunction

	reg                phase;
	reg                have;
	reg        [3:0]   count;
	reg signed [W-1:0] aLoad;
	reg signed [W-1:0] aPos;
	reg signed [W-1:0] bLoad;
	reg signed [W-1:0] bPos;
	wire signed [W:0]   drop = aLoad - load;
	wire signed [W:0]   span = aLoad - bLoad;
	wire signed [W:0]   rise = load - bLoad;
	wire signed [W+8:0] need = span * $signed({1'b0, quarters(rate)});
	wire signed [W+8:0] got  = {{6{rise[W]}}, rise, 2'b00};

	// hunt high point, then low point, then confirm on the rebound
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			phase <= 1'b0;
			have <= 1'b0;
			count <= 4'h0;
			aLoad <= {W{1'b0}};
			aPos <= {W{1'b0}};
			bLoad <= {W{1'b0}};
			bPos <= {W{1'b0}};
			found <= 1'b0;
			maxLoad <= {W{1'b0}};
			maxPos <= {W{1'b0}};
			minLoad <= {W{1'b0}};
			minPos <= {W{1'b0}};
		end else if (restart) begin
			phase <= 1'b0;
			have <= 1'b0;
			count <= 4'h0;
			found <= 1'b0;
		end else if (strobe && armed && !found) begin
			// while confirming, a rise past A is still the rebound, not a new high
			if (!phase) begin
				if (!have || load > aLoad) begin
					aLoad <= load;
					aPos <= pos;
					have <= 1'b1;
					phase <= 1'b0;
				end else if (drop > $signed({1'b0, diff})) begin
					bLoad <= load;
					bPos <= pos;
					phase <= 1'b1;
				end
			end else if (load < bLoad) begin
				bLoad <= load;
				bPos <= pos;
			end else if (got > need) begin
				count <= count + 4'h1;
				if (count + 4'h1 == ordinal) begin
					found <= 1'b1;
					maxLoad <= aLoad;
					maxPos <= aPos;
					minLoad <= bLoad;
					minPos <= bPos;
				end
				// next pair starts from this rebound point
				aLoad <= load;
				aPos <= pos;
				phase <= 1'b0;
			end
		end
	end
endmodule

// ---- wshj_inflect.v ----
// inflection point detector over position-indexed load history
// assumes one sample per position unit; dropped units keep stale history
`timescale 1ns/1ps
`include "wshj_defs.vh"
module wshj_inflect #(
	parameter W  = 16,
	parameter AW = 11
) (
	input  wire                sys_clk,
	input  wire                rst,
	input  wire                restart,
	input  wire                strobe,
	input  wire                armed,
	input  wire signed [W-1:0] load,
	input  wire signed [W-1:0] pos,
	input  wire        [9:0]   intA,
	input  wire        [9:0]   intB,
	input  wire        [W-1:0] thresh,
	output reg                 found,
	output reg  signed [W-1:0] bestLoad,
	output reg  signed [W-1:0] bestPos
);
	reg signed [W-1:0] hist [0:(1<<AW)-1];
	reg        [W:0]   bestDiff;
	reg        [AW:0]  filled;
	wire signed [W-1:0] jPos  = pos - $signed({6'h00, intB});
	wire signed [W-1:0] kPos  = jPos - $signed({6'h00, intA});
	wire signed [W-1:0] jLoad = hist[jPos[AW-1:0]];
	wire signed [W-1:0] kLoad = hist[kPos[AW-1:0]];
	wire signed [W+1:0] chgB  = load - jLoad;
	wire signed [W+1:0] chgA  = jLoad - kLoad;
	wire signed [W+1:0] delta = chgB - chgA;
	wire        [W:0]   mag   = delta[W+1] ? -delta[W:0] : delta[W:0];
	wire                ready = filled > {1'b0, intA} + {1'b0, intB};

	// history is plain storage, no reset needed
	always @(posedge sys_clk) begin
		if (strobe)
			hist[pos[AW-1:0]] <= load;
	end

	// keep the junction with the largest change difference
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			found <= 1'b0;
			bestDiff <= {(W+1){1'b0}};
			bestLoad <= {W{1'b0}};
			bestPos <= {W{1'b0}};
			filled <= {(AW+1){1'b0}};
		end else if (restart) begin
			found <= 1'b0;
			bestDiff <= {(W+1){1'b0}};
			filled <= {(AW+1){1'b0}};
		end else if (strobe && armed) begin
			if (!filled[AW])
				filled <= filled + 1'b1;
			if (ready && mag > {1'b0, thresh} && mag > bestDiff) begin
				found <= 1'b1;
				bestDiff <= mag;
				bestLoad <= jLoad;
				bestPos <= jPos;
			end
		end
	end
endmodule

// ---- wshj_top_props.sv ----
// checker of start, close and verdict relations at the top ports
// assumes the bench leaves W at 16 and holds settings steady around pulses
`timescale 1ns/1ps
module wshj_top_props (
	input wire               sys_clk,
	input wire               rst,
	input wire               measStart,
	input wire               measEnd,
	input wire               sampleValid,
	input wire               dispAxis,
	input wire        [2:0]  numSect,
	input wire        [19:0] cfgMode,
	input wire signed [15:0] endPosition,
	input wire        [79:0] loadHi,
	input wire        [79:0] loadLo,
	input wire        [79:0] heldPos,
	input wire        [4:0]  sectDone,
	input wire        [4:0]  sectPass,
	input wire        [4:0]  sectFail,
	input wire        [4:0]  cfgError,
	input wire               busy
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// start clears every verdict and raises busy
	start_clear_a: assert property (measStart |=> sectDone == 5'h00
		&& sectPass == 5'h00 && sectFail == 5'h00) else $error("start left results");
	busy_run_a: assert property (measStart |=> busy)
		else $error("busy not raised");
	// a verdict is one of two, never both
	verdict_excl_a: assert property ((sectPass & sectFail) == 5'h00)
		else $error("pass and fail together");
	done_verdict_a: assert property ((sectDone & ~(sectPass | sectFail)) == 5'h00)
		else $error("done without verdict");
	// results only move on samples, the start pulse or the end pulse; two cycles of slack
	quiet_hold_a: assert property ((!sampleValid && !measEnd && !measStart) [*3]
		|=> $stable(sectDone) && $stable(heldPos)) else $error("results moved while idle");
	done_sticky_a: assert property (!measStart
		|=> (sectDone & $past(sectDone)) == $past(sectDone)) else $error("done dropped");
	sect_count_a: assert property ((numSect == 3'h0 || numSect > 3'h5)
		|=> cfgError == 5'h1F) else $error("bad section count accepted");
	load_order_a: assert property ($signed(loadHi[15:0]) < $signed(loadLo[15:0])
		|=> cfgError[0]) else $error("inverted limits accepted");
	end_pos_a: assert property (measEnd && dispAxis && numSect == 3'h1
		&& cfgMode[3:0] == 4'h9 |=> heldPos[15:0] == $past(endPosition) && sectDone[0])
		else $error("end position not held");

	run_end_c: cover property (measEnd && busy);
	pass_c: cover property (sectPass != 5'h00);
	fail_c: cover property (sectFail != 5'h00);
endmodule

// ---- wshj_src.sv ----
// front end model: sample strobe, load, position and external hold level
// assumes the bench calls send once per sample with positions in order
`timescale 1ns/1ps
module wshj_src (
	input  wire               sys_clk,
	output reg                sampleValid,
	output reg  signed [15:0] sampleLoad,
	output reg  signed [15:0] position_value,
	output reg                holdIn
);
	initial begin
		sampleValid = 1'b0;
		sampleLoad = 16'h0000;
		position_value = 16'h0000;
		holdIn = 1'b0;
	end

	// one strobe per sample; data is inverted after so stale values never match
	task send(input logic signed [15:0] ld, input logic signed [15:0] ps, input logic hd);
		begin
			@(posedge sys_clk);
			sampleValid <= 1'b1;
			sampleLoad <= ld;
			position_value <= ps;
			holdIn <= hd;
			@(posedge sys_clk);
			sampleValid <= 1'b0;
			sampleLoad <= ~ld;
			position_value <= ~ps;
		end
	endtask
endmodule

// ---- wshj_tb_top.sv ----
// bench for the section hold and judge block: front end model plus call sequences
// assumes front reference only; results are read two cycles after the end pulse
`timescale 1ns/1ps
module wshj_tb_top;
	reg                sys_clk = 1'b0, rst = 1'b1, measStart = 1'b0, measEnd = 1'b0;
	reg                extSwitch = 1'b0, backRef = 1'b0, dispAxis = 1'b0;
	reg         [2:0]  numSect = 3'h1;
	reg signed  [15:0] endPosition = 16'h0000;
	reg         [19:0] cfgMode = 20'h00000, relRate = 20'h00000, relOrdinal = 20'h00000;
	reg         [79:0] cfgStart = 80'h0, cfgEnd = 80'h0, loadHi = 80'h0, loadLo = 80'h0;
	reg         [79:0] posHi = 80'h0, posLo = 80'h0, startLoad = 80'h0, relDiff = 80'h0;
	reg         [79:0] inflDiff = 80'h0;
	reg         [49:0] intA = 50'h0, intB = 50'h0;
	reg         [4:0]  startLoadEn = 5'h00;
	wire               sampleValid, holdIn, busy;
	wire signed [15:0] sampleLoad, position_value;
	wire        [79:0] heldLoad, heldPos;
	wire        [4:0]  sectDone, sectPass, sectFail, cfgError;
	reg signed  [15:0] ld [0:31];
	int                err_total = 0, comparisons = 0;
	// sample, peak, bottom, p-p, average, always over loads 0..80 at positions 2..10
	logic       [3:0]  mt [0:5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h0};
	logic       [15:0] ml [0:5] = '{16'h0000, 16'h0050, 16'h0000, 16'h0050, 16'h0028, 16'h0000};
	logic       [15:0] mp [0:5] = '{16'h0002, 16'h000A, 16'h0002, 16'h0000, 16'h0000, 16'h0000};

	wshj_top i_wshj_top (.sys_clk, .rst, .measStart, .measEnd, .sampleValid, .sampleLoad,
		.position_value, .endPosition, .holdIn, .extSwitch, .backRef, .dispAxis, .numSect,
		.cfgMode, .cfgStart, .cfgEnd, .loadHi, .loadLo, .posHi, .posLo, .startLoad,
		.startLoadEn, .relDiff, .relRate, .relOrdinal, .intA, .intB, .inflDiff, .heldLoad,
		.heldPos, .sectDone, .sectPass, .sectFail, .cfgError, .busy);
	wshj_src i_wshj_src (.sys_clk, .sampleValid, .sampleLoad, .position_value, .holdIn);

	initial begin
		forever #4 sys_clk = ~sys_clk;
	end

	task check(input logic [15:0] seen, input logic [15:0] want);
		begin
			comparisons++;
			if (seen !== want) begin
				err_total++;
				$display("ERROR %0t: saw %h expected %h", $time, seen, want);
			end
		end
	endtask

	task results;
		begin
			if (err_total == 0 && comparisons > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask

	// valid settings for all sections; ten-unit spans keep the margin
	task dflt;
		begin
			@(posedge sys_clk);
			{extSwitch, dispAxis, numSect, startLoadEn} <= {2'b00, 3'h1, 5'h00};
			cfgMode <= {5{4'h2}};
			{cfgStart, cfgEnd} <= {{5{16'h0000}}, {5{16'h000A}}};
			{loadHi, loadLo} <= {{5{16'h005A}}, {5{16'hFFCE}}};
			{posHi, posLo} <= {{5{16'h0064}}, {5{16'h0000}}};
			{relDiff, relRate, relOrdinal} <= {{5{16'h0032}}, {5{4'h3}}, {5{4'h1}}};
			{intA, intB} <= {{10{10'h001}}};
		end
	endtask

	// one measurement: start, n samples from p0, end; hold high on samples 3..5 if ext
	task run(input int n, input int p0, input logic ext);
		begin
			@(posedge sys_clk);
			measStart <= 1'b1;
			@(posedge sys_clk);
			measStart <= 1'b0;
			#1;
			check(busy, 1'b1);
			for (int i = 0; i < n; i++)
				i_wshj_src.send(ld[i], 16'(p0 + i), ext && i > 2 && i < 6);
			@(posedge sys_clk);
			measEnd <= 1'b1;
			@(posedge sys_clk);
			measEnd <= 1'b0;
			repeat (2) @(posedge sys_clk);
			#1;
			check(busy, 1'b0);
		end
	endtask

	initial begin
		#500000;
		err_total++;
		results;
	end

	initial begin
		int k;
		for (k = 0; k < 32; k++)
			ld[k] = 16'(k * 10);
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		check(sectDone, 5'h00);
		dflt;
		repeat (2) @(posedge sys_clk);
		#1;
		check(cfgError, 5'h00);
		// hold modes with inclusive limits 0..80; first sample lands past start
		@(posedge sys_clk);
		{loadHi, loadLo} <= {{5{16'h0050}}, {5{16'h0000}}};
		for (k = 0; k < 6; k++) begin
			@(posedge sys_clk);
			cfgMode[3:0] <= mt[k];
			run(9, 2, 1'b0);
			check(heldLoad[15:0], ml[k]);
			check(heldPos[15:0], mp[k]);
			check({sectDone[0], sectPass}, 6'h21);
		end
		// peak one count over the limit fails
		@(posedge sys_clk);
		{loadHi[15:0], cfgMode[3:0]} <= {16'h004F, 4'h2};
		run(9, 2, 1'b0);
		check(sectFail, 5'h01);
		// shared point 10 goes to the later section
		dflt;
		@(posedge sys_clk);
		{numSect, cfgMode[7:4]} <= {3'h2, 4'h3};
		{cfgStart[31:16], cfgEnd[31:16]} <= {16'h000A, 16'h0014};
		ld[10] = 16'hFFCE;
		run(21, 0, 1'b0);
		check(heldLoad[15:0], 16'h005A);
		check(heldLoad[31:16], 16'hFFCE);
		check(heldPos[31:16], 16'h000A);
		check(sectPass, 5'h03);
		// relative max, min, then a rate of four that never confirms
		{ld[0], ld[1], ld[2], ld[3], ld[4]} = {16'h0000, 16'h0032, 16'h0064, 16'h0014, 16'h006E};
		@(posedge sys_clk);
		{loadHi, startLoad, startLoadEn} <= {{5{16'h00C8}}, {5{16'h000A}}, 5'h01};
		for (k = 0; k < 3; k++) begin
			@(posedge sys_clk);
			cfgMode[3:0] <= (k == 1) ? 4'h6 : 4'h5;
			relRate[3:0] <= (k == 2) ? 4'h9 : 4'h3;
			run(5, 0, 1'b0);
			if (k < 2)
				check(heldLoad[15:0], (k == 1) ? 16'h0014 : 16'h0064);
			check(sectPass, (k < 2) ? 5'h01 : 5'h00);
		end
		// external hold over samples 3..5 (loads 20, 110, 50)
		@(posedge sys_clk);
		{extSwitch, cfgMode[3:0]} <= {1'b1, 4'h2};
		run(7, 0, 1'b1);
		check(heldLoad[15:0], 16'h006E);
		check(heldPos[15:0], 16'h0004);
		// end position at the limit and one past it
		for (k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			{extSwitch, dispAxis, numSect, cfgMode[3:0]} <= {1'b0, 1'b1, 3'h1, 4'h9};
			endPosition <= k ? 16'h0065 : 16'h0064;
			run(3, 0, 1'b0);
			check(heldPos[15:0], k ? 16'h0065 : 16'h0064);
			check(sectPass, k ? 5'h00 : 5'h01);
		end
		// rejected settings, one per pass
		for (k = 0; k < 7; k++) begin
			dflt;
			@(posedge sys_clk);
			cfgMode[3:0] <= (k == 5) ? 4'h7 : (k == 6) ? 4'h9 : (k > 2) ? 4'h5 : 4'h2;
			dispAxis <= (k == 6);
			case (k)
				0: cfgStart[15:0] <= 16'h0014;
				1: loadHi[15:0] <= 16'hFFCD;
				2: numSect <= 3'h0;
				3: relOrdinal[3:0] <= 4'h0;
				4: relDiff[15:0] <= 16'h0000;
				5: intA[9:0] <= 10'h000;
				default: numSect <= 3'h2;
			endcase
			repeat (2) @(posedge sys_clk);
			#1;
			check(cfgError, (k == 2) ? 5'h1F : 5'h01);
		end
		results;
	end
endmodule

bind wshj_top wshj_top_props i_wshj_top_props (.sys_clk, .rst, .measStart, .measEnd,
	.sampleValid, .dispAxis, .numSect, .cfgMode, .endPosition, .loadHi, .loadLo, .heldPos,
	.sectDone, .sectPass, .sectFail, .cfgError, .busy);
